// >>> hw/abcu_top.sv
// Single-block 128-bit cipher engine with byte-wide key and state ports
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "abcu_consts.svh"

// Notes on behaviour
// - One 128-bit block and 128-bit key, each given as 16 byte writes.
// - Result stands in state memory 375 clocks after the start.
// - Software direction bit chooses encryption or decryption.
// - XOR load mode combines each written state byte with the stored byte.
// - Key and state are 16-byte memories reached only through their ports.
// - Each memory has 4-bit read and write pointers, zero after reset.
// - A port read advances the read pointer; a write the write pointer.
// - Any control register access clears all four pointers.
// - Pointers wrap to zero after sixteen accesses.
// - Pointers are not readable by software.
// - In XOR mode a state write advances both state pointers.
// - Key and state ports are ignored while an operation runs.
// - State memory holds input, then working state, then output block.
// - Decryption expects the last round key; encryption the cipher key.
// - Key reads give loaded key, last round key, or recovered cipher key.
// - Completion sets the ready flag and, when enabled, the interrupt.
// - Completion also pulses a DMA trigger.
// - Optional self-start once state memory is fully loaded.
// - Start bit runs; writing zero aborts; ready or error clears it.
// - Ready clears on state read or by writing one.
// - Error on start with access count not multiple of 16, or control access while running.
// - Self-start needs auto set first and all pointers zero.
module abcu_top #(
  parameter int RUN_CYCLES = `ABCU_RUN_CYCLES
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // Register port
  input  wire abcu_pkg::abcu_addr_t i_addr,
  input  wire abcu_pkg::abcu_byte_t i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output abcu_pkg::abcu_byte_t      o_rdata,
  // Completion signals
  output logic                     o_irq,
  output logic                     o_dma_trig
);
  import abcu_pkg::*;

  localparam int CW = $clog2(RUN_CYCLES + 1);

  // Refuse run lengths too short to hold all rounds
  if (RUN_CYCLES < `ABCU_MIN_RUN) begin : g_bad_run
    $error("RUN_CYCLES too small for the round sequence");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field arithmetic

  function automatic abcu_byte_t xt(input abcu_byte_t a);
    return {a[6:0], 1'b0} ^ (a[7] ? `ABCU_GF_POLY : 8'h00);
  endfunction

  function automatic abcu_byte_t gmul(input abcu_byte_t a, input abcu_byte_t b);
    abcu_byte_t r;
    abcu_byte_t p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction

  // Inverse as x^254; zero maps to zero as the cipher requires
  function automatic abcu_byte_t ginv(input abcu_byte_t x);
    abcu_byte_t x2, x3, x12, x15, x240;
    x2   = gmul(x, x);
    x3   = gmul(x2, x);
    x12  = gmul(gmul(x3, x3), gmul(x3, x3));
    x15  = gmul(x12, x3);
    x240 = gmul(x15, x15);
    x240 = gmul(x240, x240);
    x240 = gmul(x240, x240);
    x240 = gmul(x240, x240);
    return gmul(gmul(x240, x12), x2);
  endfunction

  function automatic abcu_byte_t rl(input abcu_byte_t b, input int n);
    logic [15:0] w;
    w = {b, b} << n;
    return w[15:8];
  endfunction

  // Substitution box computed rather than tabled, trading area for code size
  function automatic abcu_byte_t sub(input abcu_byte_t x, input logic inv);
    abcu_byte_t y;
    if (!inv) begin
      y = ginv(x);
      return y ^ rl(y, 1) ^ rl(y, 2) ^ rl(y, 3) ^ rl(y, 4) ^ `ABCU_AFFINE_C;
    end
    y = rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ `ABCU_INV_AFFINE_C;
    return ginv(y);
  endfunction

  function automatic abcu_byte_t rcon(input logic [3:0] idx);
    abcu_byte_t r;
    r = 8'h01;
    for (int i = 0; i < 10; i++) begin
      if (i < idx) r = xt(r);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Key schedule steps, one round key per call

  function automatic abcu_blk_t key_fwd(input abcu_blk_t k, input abcu_byte_t rc);
    abcu_blk_t n;
    logic [3:0][7:0] t;
    t[0] = sub(k[13], 1'b0) ^ rc;
    t[1] = sub(k[14], 1'b0);
    t[2] = sub(k[15], 1'b0);
    t[3] = sub(k[12], 1'b0);
    for (int i = 0; i < 16; i++) begin
      if (i < 4) n[i] = k[i] ^ t[i];
      else n[i] = k[i] ^ n[i-4];
    end
    return n;
  endfunction

  // Walks the schedule backward, giving the previous round key
  function automatic abcu_blk_t key_inv(input abcu_blk_t k, input abcu_byte_t rc);
    abcu_blk_t p;
    logic [3:0][7:0] t;
    p = k;
    for (int i = 4; i < 16; i++) begin
      p[i] = k[i] ^ k[i-4];
    end
    t[0] = sub(p[13], 1'b0) ^ rc;
    t[1] = sub(p[14], 1'b0);
    t[2] = sub(p[15], 1'b0);
    t[3] = sub(p[12], 1'b0);
    for (int i = 0; i < 4; i++) begin
      p[i] = k[i] ^ t[i];
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // One full round on the state; byte 4*c+r is row r of column c

  function automatic abcu_blk_t do_round(input abcu_blk_t s, input abcu_blk_t k,
                                         input logic dec, input logic last);
    abcu_blk_t a;
    abcu_blk_t m;
    logic [3:0][7:0] cf;
    cf = dec ? {8'h09, 8'h0D, 8'h0B, 8'h0E} : {8'h01, 8'h01, 8'h03, 8'h02};
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (!dec) a[4*c+r] = sub(s[4*((c+r)%4)+r], 1'b0);
        else a[4*c+r] = sub(s[4*((c+4-r)%4)+r], 1'b1);
      end
    end
    if (dec) a = a ^ k;
    m = a;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        m[4*c+r] = 8'h00;
        for (int j = 0; j < 4; j++) begin
          m[4*c+r] = m[4*c+r] ^ gmul(cf[(j+4-r)%4], a[4*c+j]);
        end
      end
    end
    if (last) m = a;
    if (!dec) m = m ^ k;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  abcu_state_t   fsm_q;
  logic [CW-1:0] cnt_q;
  abcu_blk_t     st_q;          // State memory, 16 bytes
  abcu_blk_t     key_q;         // Key memory, 16 bytes
  abcu_ptr_t     st_rp_q;
  abcu_ptr_t     st_wp_q;
  abcu_ptr_t     key_rp_q;
  abcu_ptr_t     key_wp_q;
  abcu_ptr_t     acc_q;         // Port accesses modulo sixteen
  logic          auto_q;
  logic          dec_q;
  logic          xor_q;
  logic          srst_q;
  logic          ready_q;
  logic          err_q;
  logic [`ABCU_INTLVL_MSB:0] lvl_q;
  abcu_byte_t    rdata_q;
  logic          irq_q;
  logic          dma_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  logic running;
  logic ctrl_acc, ctrl_wr;
  logic st_wr, st_rd, key_wr, key_rd;
  logic go_manual, go_auto, bad_start, done, abort;
  logic [3:0] rnd;

  assign running  = (fsm_q == ABCU_RUN);
  assign ctrl_acc = (i_wr || i_rd) && (i_addr == `ABCU_ADDR_CTRL);
  assign ctrl_wr  = i_wr && (i_addr == `ABCU_ADDR_CTRL);
  // Port accesses are dropped outright while running
  assign st_wr  = i_wr && (i_addr == `ABCU_ADDR_STATE) && !running;
  assign st_rd  = i_rd && (i_addr == `ABCU_ADDR_STATE) && !running;
  assign key_wr = i_wr && (i_addr == `ABCU_ADDR_KEY) && !running;
  assign key_rd = i_rd && (i_addr == `ABCU_ADDR_KEY) && !running;

  // Start only when key and state traffic came in whole blocks
  assign go_manual = ctrl_wr && i_wdata[`ABCU_CTRL_START] && !running
                     && (acc_q == 4'h0);
  assign bad_start = ctrl_wr && i_wdata[`ABCU_CTRL_START] && !running
                     && (acc_q != 4'h0);
  // Pointer state is trusted here; a misaligned load runs with a wrong key
  assign go_auto = auto_q && st_wr && (st_wp_q == `ABCU_PTR_LAST);
  // Any control access while running is an error, which also stops the run
  assign abort = running && ctrl_acc;
  assign done  = running && !abort && (cnt_q == CW'(RUN_CYCLES - 1));
  assign rnd   = cnt_q[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Run counter; result appears after the full fixed latency
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fsm_q <= ABCU_IDLE;
      cnt_q <= '0;
    end else if (srst_q) begin
      fsm_q <= ABCU_IDLE;
      cnt_q <= '0;
    end else if (!running) begin
      cnt_q <= '0;
      if (go_manual || go_auto) fsm_q <= ABCU_RUN;
    end else if (abort || done) begin
      fsm_q <= ABCU_IDLE;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Software reset lasts exactly one cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= ctrl_wr && !running && i_wdata[`ABCU_CTRL_SRST];
    end
  end

  // Mode bits can only change while idle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      auto_q <= 1'b0;
      dec_q  <= 1'b0;
      xor_q  <= 1'b0;
    end else if (srst_q) begin
      auto_q <= 1'b0;
      dec_q  <= 1'b0;
      xor_q  <= 1'b0;
    end else if (ctrl_wr && !running) begin
      auto_q <= i_wdata[`ABCU_CTRL_AUTO];
      dec_q  <= i_wdata[`ABCU_CTRL_DECRYPT];
      xor_q  <= i_wdata[`ABCU_CTRL_XOR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pointers and access count

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_rp_q  <= '0;
      st_wp_q  <= '0;
      key_rp_q <= '0;
      key_wp_q <= '0;
    end else if (srst_q || ctrl_acc) begin
      st_rp_q  <= '0;
      st_wp_q  <= '0;
      key_rp_q <= '0;
      key_wp_q <= '0;
    end else begin
      // Four-bit counters roll over after sixteen steps
      if (st_rd || (st_wr && xor_q)) st_rp_q <= st_rp_q + 4'h1;
      if (st_wr) st_wp_q <= st_wp_q + 4'h1;
      if (key_rd) key_rp_q <= key_rp_q + 4'h1;
      if (key_wr) key_wp_q <= key_wp_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= '0;
    end else if (srst_q) begin
      acc_q <= '0;
    end else if (st_wr || st_rd || key_wr || key_rd) begin
      acc_q <= acc_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and key memories

  // Cycle 0 adds the loaded key, cycles 1 to 10 run the rounds
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else if (srst_q) begin
      st_q <= '0;
    end else if (running) begin
      if (cnt_q == CW'(0)) begin
        st_q <= st_q ^ key_q;
      end else if (cnt_q <= CW'(`ABCU_LAST_ROUND)) begin
        st_q <= do_round(st_q, dec_q ? key_inv(key_q, rcon(4'(`ABCU_LAST_ROUND - rnd)))
                                     : key_fwd(key_q, rcon(4'(rnd - 4'h1))),
                         dec_q, rnd == `ABCU_LAST_ROUND);
      end
    end else if (st_wr) begin
      if (xor_q) st_q[st_wp_q] <= st_q[st_wp_q] ^ i_wdata;
      else st_q[st_wp_q] <= i_wdata;
    end
  end

  // Key memory steps with the rounds and so ends on the far round key
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      key_q <= '0;
    end else if (srst_q) begin
      key_q <= '0;
    end else if (running) begin
      if (cnt_q >= CW'(1) && cnt_q <= CW'(`ABCU_LAST_ROUND)) begin
        if (dec_q) key_q <= key_inv(key_q, rcon(4'(`ABCU_LAST_ROUND - rnd)));
        else key_q <= key_fwd(key_q, rcon(4'(rnd - 4'h1)));
      end
    end else if (key_wr) begin
      key_q[key_wp_q] <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags

  // Completion set wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ready_q <= 1'b0;
    end else if (srst_q) begin
      ready_q <= 1'b0;
    end else if (done) begin
      ready_q <= 1'b1;
    end else if (st_rd || (i_wr && (i_addr == `ABCU_ADDR_STATUS)
                           && i_wdata[`ABCU_STAT_READY])) begin
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_q <= 1'b0;
    end else if (srst_q) begin
      err_q <= 1'b0;
    end else if (bad_start || abort) begin
      err_q <= 1'b1;
    end else if (i_wr && (i_addr == `ABCU_ADDR_STATUS) && i_wdata[`ABCU_STAT_ERROR]) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvl_q <= '0;
    end else if (srst_q) begin
      lvl_q <= '0;
    end else if (i_wr && (i_addr == `ABCU_ADDR_INTCTRL)) begin
      lvl_q <= i_wdata[`ABCU_INTLVL_MSB:0];
    end
  end

  // Request follows the ready flag one cycle later; any nonzero level enables
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      irq_q <= ready_q && (lvl_q != '0);
      dma_q <= done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= '0;
    end else if (!i_rd) begin
      rdata_q <= '0;
    end else if (i_addr == `ABCU_ADDR_CTRL) begin
      rdata_q <= '0;
      rdata_q[`ABCU_CTRL_START]   <= running;
      rdata_q[`ABCU_CTRL_AUTO]    <= auto_q;
      rdata_q[`ABCU_CTRL_DECRYPT] <= dec_q;
      rdata_q[`ABCU_CTRL_XOR]     <= xor_q;
    end else if (i_addr == `ABCU_ADDR_STATUS) begin
      rdata_q <= '0;
      rdata_q[`ABCU_STAT_ERROR] <= err_q;
      rdata_q[`ABCU_STAT_READY] <= ready_q;
    end else if (i_addr == `ABCU_ADDR_STATE) begin
      rdata_q <= running ? 8'h00 : st_q[st_rp_q];
    end else if (i_addr == `ABCU_ADDR_KEY) begin
      rdata_q <= running ? 8'h00 : key_q[key_rp_q];
    end else if (i_addr == `ABCU_ADDR_INTCTRL) begin
      rdata_q <= {6'h00, lvl_q};
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata    = rdata_q;
  assign o_irq      = irq_q;
  assign o_dma_trig = dma_q;

endmodule

// >>> hw/abcu_consts.svh
// Register offsets, field positions and timing counts of the block cipher unit
`ifndef ABCU_CONSTS_SVH
`define ABCU_CONSTS_SVH

// Register offsets
`define ABCU_ADDR_CTRL     3'h0
`define ABCU_ADDR_STATUS   3'h1
`define ABCU_ADDR_STATE    3'h2
`define ABCU_ADDR_KEY      3'h3
`define ABCU_ADDR_INTCTRL  3'h4

// Control register fields
`define ABCU_CTRL_START    7
`define ABCU_CTRL_AUTO     6
`define ABCU_CTRL_SRST     5
`define ABCU_CTRL_DECRYPT  4
`define ABCU_CTRL_XOR      2

// Status register fields
`define ABCU_STAT_ERROR    7
`define ABCU_STAT_READY    0

// Interrupt level field
`define ABCU_INTLVL_MSB    1

// Timing: cycles from start to result, rounds, least usable run length
`define ABCU_RUN_CYCLES    375
`define ABCU_LAST_ROUND    4'hA
`define ABCU_MIN_RUN       12

// Field arithmetic constants and the last pointer value
`define ABCU_GF_POLY       8'h1B
`define ABCU_AFFINE_C      8'h63
`define ABCU_INV_AFFINE_C  8'h05
`define ABCU_PTR_LAST      4'hF

`endif

// >>> hw/abcu_pkg.sv
// Types shared by the block cipher unit
package abcu_pkg;
  typedef logic [2:0]       abcu_addr_t;
  typedef logic [7:0]       abcu_byte_t;
  typedef logic [15:0][7:0] abcu_blk_t;
  typedef logic [3:0]       abcu_ptr_t;
  typedef enum logic {ABCU_IDLE, ABCU_RUN} abcu_state_t;
endpackage

// >>> sim/abcu_host_model.sv
// Bus master standing in for the processor core and the DMA controller
`timescale 1ns/10ps
module abcu_host_model (
  // Clock
  input  wire logic                 i_clk,
  // Register port towards the unit
  output abcu_pkg::abcu_addr_t      o_addr,
  output abcu_pkg::abcu_byte_t      o_wdata,
  output logic                      o_wr,
  output logic                      o_rd,
  input  wire abcu_pkg::abcu_byte_t i_rdata
);
  import abcu_pkg::*;
  ////////////////////////////////////////
  // Idle bus: strobes low, address parked on a reserved offset
  initial begin
    o_addr = 3'h7;
    o_wdata = 8'hA5;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Write strobe for one cycle; data is inverted on release so stale values never look valid
  task automatic wr(input abcu_addr_t a, input abcu_byte_t d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken inside that cycle
  task automatic rd(input abcu_addr_t a, output abcu_byte_t d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
  // A key or a block goes in as sixteen byte writes, byte 0 first
  task automatic load(input abcu_addr_t a, input abcu_blk_t b);
    for (int i = 0; i < 16; i++) begin
      wr(a, b[i]);
    end
  endtask
endmodule

// >>> sim/abcu_chk.sv
// Port-level assertions for the block cipher unit
`timescale 1ns/10ps
`include "abcu_consts.svh"
module abcu_chk #(
  parameter int RUN_CYCLES = 375
) (
  input wire logic                 i_clk,
  input wire logic                 i_sys_rst,
  input wire abcu_pkg::abcu_addr_t i_addr,
  input wire abcu_pkg::abcu_byte_t i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire abcu_pkg::abcu_byte_t o_rdata,
  input wire logic                 o_irq,
  input wire logic                 o_dma_trig
);
  import abcu_pkg::*;
  logic        ctrl_wr;
  logic [15:0] since_q;
  logic [1:0]  lvl_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  // Cycles since a start write or a state write (auto start fires on the last one)
  assign ctrl_wr = i_wr && (i_addr == `ABCU_ADDR_CTRL);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_q <= 16'h0000;
    end else if ((ctrl_wr && i_wdata[`ABCU_CTRL_START]) || (i_wr && i_addr == `ABCU_ADDR_STATE)) begin
      since_q <= 16'h0001;
    end else if (since_q != 16'hFFFF) begin
      since_q <= since_q + 16'h0001;
    end
  end
  // Interrupt level as software set it; assumes soft reset is only written while idle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvl_q <= 2'h0;
    end else if (ctrl_wr && i_wdata[`ABCU_CTRL_SRST]) begin
      lvl_q <= 2'h0;
    end else if (i_wr && i_addr == `ABCU_ADDR_INTCTRL) begin
      lvl_q <= i_wdata[1:0];
    end
  end
  ////////////////////////////////////////
  chk_run_length: assert property (o_dma_trig |-> since_q == 16'(RUN_CYCLES + 1))
    else $error("completion not at the run length");
  chk_no_early_done: assert property (ctrl_wr && i_wdata[`ABCU_CTRL_START] |=> !o_dma_trig [*8])
    else $error("completion too soon after start");
  chk_dma_one_cycle: assert property (o_dma_trig |=> !o_dma_trig)
    else $error("dma trigger wider than one cycle");
  chk_irq_follows: assert property (o_dma_trig && lvl_q != 2'h0 |=> o_irq)
    else $error("interrupt missing after completion");
  chk_irq_enabled: assert property (o_irq |-> $past(lvl_q) != 2'h0)
    else $error("interrupt while disabled");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read answer");
  chk_rsvd_addr: assert property ($past(i_rd) && $past(i_addr) > 3'h4 |-> o_rdata == 8'h00)
    else $error("reserved offset reads nonzero");
  chk_status_bits: assert property ($past(i_rd) && $past(i_addr) == `ABCU_ADDR_STATUS
    |-> o_rdata[6:1] == 6'h00)
    else $error("status unused bits nonzero");
  cover property (o_dma_trig);
  cover property (o_irq);
  cover property ($past(i_rd) && $past(i_addr) == `ABCU_ADDR_STATUS && o_rdata[7]);
endmodule
bind abcu_top abcu_chk #(.RUN_CYCLES(RUN_CYCLES)) i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_dma_trig(o_dma_trig));

// >>> sim/abcu_bench.sv
// Self-checking bench for the block cipher unit
`timescale 1ns/10ps
`include "abcu_consts.svh"
module abcu_bench;
  import abcu_pkg::*;
  localparam int RUN = 20; // Short run keeps the test quick; waits and run-length checks scale with it, the 6000-cycle hang cut does not
  // Standard test block, byte 0 in the low byte
  localparam abcu_blk_t KEY = 128'h0F0E0D0C0B0A09080706050403020100;
  localparam abcu_blk_t PT  = 128'hFFEEDDCCBBAA99887766554433221100;
  localparam abcu_blk_t CT  = 128'h5AC5B47080B7CDD830047B6AD8E0C469;
  localparam abcu_blk_t RK  = 128'hC5302B4D8BA707F3174A94E37F1D1113;
  logic       i_clk;
  logic       i_sys_rst;
  logic       i_wr;
  logic       i_rd;
  logic       o_irq;
  logic       o_dma_trig;
  abcu_addr_t i_addr;
  abcu_byte_t i_wdata;
  abcu_byte_t o_rdata;
  abcu_byte_t v;
  int         n_fail;
  int         samples_checked;
  int         cyc;
  ////////////////////////////////////////
  abcu_host_model i_host (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd), .i_rdata(o_rdata));
  abcu_top #(.RUN_CYCLES(RUN)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_dma_trig(o_dma_trig));
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Cut a hang short; the whole sequence needs well under this
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input abcu_byte_t exp, input abcu_byte_t got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input abcu_addr_t a, input abcu_byte_t exp, input string what);
    i_host.rd(a, v);
    chk(what, exp, v);
  endtask
  task automatic blk_chk(input abcu_addr_t a, input abcu_blk_t exp, input string what);
    for (int i = 0; i < 16; i++) begin
      rchk(a, exp[i], what);
    end
  endtask
  // Completion is due RUN edges after the edge that took the start; irq one later
  task automatic wait_done(input logic irq_on);
    int k;
    k = 0;
    while (o_dma_trig !== 1'b1 && k < 500) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk("run length", 8'(RUN), 8'(k));
    @(posedge i_clk);
    #1;
    chk("irq", {7'h00, irq_on}, {7'h00, o_irq});
  endtask
  ////////////////////////////////////////
  initial begin
    i_sys_rst = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // Control and status places, reserved offsets included; byte ports left untouched
    for (int a = 0; a < 8; a++) begin
      if (a != 2 && a != 3) rchk(abcu_addr_t'(a), 8'h00, "reset value");
    end
    // Encryption with interrupt enabled
    i_host.wr(`ABCU_ADDR_INTCTRL, 8'h01);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h00);
    i_host.load(`ABCU_ADDR_KEY, KEY);
    i_host.load(`ABCU_ADDR_STATE, PT);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h80);
    wait_done(1'b1);
    rchk(`ABCU_ADDR_STATUS, 8'h01, "ready");
    i_host.wr(`ABCU_ADDR_CTRL, 8'h00);
    rchk(`ABCU_ADDR_STATE, CT[0], "cipher");
    rchk(`ABCU_ADDR_STATUS, 8'h00, "ready clear");
    chk("irq drop", 8'h00, {7'h00, o_irq});
    for (int i = 1; i < 16; i++) rchk(`ABCU_ADDR_STATE, CT[i], "cipher");
    blk_chk(`ABCU_ADDR_KEY, RK, "last round key");
    rchk(`ABCU_ADDR_STATE, CT[0], "wrap");
    // Odd access count: start refused with error, no result ever comes
    i_host.wr(`ABCU_ADDR_CTRL, 8'h90);
    repeat (RUN + 4) @(posedge i_clk);
    rchk(`ABCU_ADDR_STATUS, 8'h80, "count error");
    i_host.wr(`ABCU_ADDR_STATUS, 8'h80);
    rchk(`ABCU_ADDR_STATUS, 8'h00, "error clear");
    // Decryption with the last round key loaded from RK, which the key readback above checked
    i_host.wr(`ABCU_ADDR_CTRL, 8'h10);
    for (int i = 0; i < 15; i++) rchk(`ABCU_ADDR_STATE, CT[i], "cipher again");
    i_host.load(`ABCU_ADDR_KEY, RK);
    i_host.load(`ABCU_ADDR_STATE, CT);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h90);
    wait_done(1'b1);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h10);
    blk_chk(`ABCU_ADDR_STATE, PT, "plain");
    blk_chk(`ABCU_ADDR_KEY, KEY, "recovered key");
    // XOR loading after soft reset; read pointer moves with each write
    i_host.wr(`ABCU_ADDR_CTRL, 8'h20);
    rchk(`ABCU_ADDR_INTCTRL, 8'h00, "soft reset");
    i_host.wr(`ABCU_ADDR_CTRL, 8'h04);
    i_host.load(`ABCU_ADDR_STATE, PT);
    i_host.load(`ABCU_ADDR_STATE, KEY);
    i_host.wr(`ABCU_ADDR_STATE, 8'h3C);
    rchk(`ABCU_ADDR_STATE, PT[1] ^ KEY[1], "xor read pointer");
    i_host.wr(`ABCU_ADDR_CTRL, 8'h00);
    rchk(`ABCU_ADDR_STATE, PT[0] ^ KEY[0] ^ 8'h3C, "xor");
    for (int i = 1; i < 16; i++) rchk(`ABCU_ADDR_STATE, PT[i] ^ KEY[i], "xor");
    // Self start: auto set first with all pointers zero
    i_host.wr(`ABCU_ADDR_CTRL, 8'h20);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h40);
    i_host.load(`ABCU_ADDR_KEY, KEY);
    i_host.load(`ABCU_ADDR_STATE, PT);
    wait_done(1'b0);
    i_host.wr(`ABCU_ADDR_CTRL, 8'h00);
    blk_chk(`ABCU_ADDR_STATE, CT, "auto result");
    // Control access in mid-run aborts it and flags an error; byte ports stay shut
    i_host.wr(`ABCU_ADDR_CTRL, 8'h80);
    rchk(`ABCU_ADDR_STATE, 8'h00, "locked port");
    rchk(`ABCU_ADDR_STATUS, 8'h00, "running");
    rchk(`ABCU_ADDR_CTRL, 8'h80, "start bit");
    repeat (RUN + 4) @(posedge i_clk);
    rchk(`ABCU_ADDR_STATUS, 8'h80, "abort");
    complete_run();
  end
endmodule
